// ---- sfat_pkg.sv ----
package sfat_pkg;
// Operation
// - Superframe is 256 slots, each slot lasting the configured slot length.
// - Beacon period opens each superframe; its start is slot zero's start.
// - Only beacon frames go out inside the beacon period.
// - Reserved slots carry frames only from devices taking part in the reservation.
// - Slots outside beacon period and reservations use prioritized contention only.
// - Every fragment carries the data unit sequence number and its fragment number.
// - Three acknowledgement policies: none, immediate per frame, block on request.
// - Missing acknowledgement leads to retransmit or discard, by type, tries and age.
// - Beacon payloads go out at the fixed beacon payload rate.
// - Headers always go at the lowest rate; other payloads may go faster.
// - In active mode beacons are sent and received every superframe.
// - Hibernation is announced in the beacon, then all traffic stops for that count.

  // Clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SLOT_DUR_NS = 1000;
  localparam int SLOT_CYC = (SLOT_DUR_NS / CLK_PERIOD_NS < 1) ? 1 : SLOT_DUR_NS / CLK_PERIOD_NS;
  localparam int ACK_TO_NS = 2000;
  localparam int ACK_TO_CYC = (ACK_TO_NS / CLK_PERIOD_NS < 1) ? 1 : ACK_TO_NS / CLK_PERIOD_NS;
  localparam logic [8:0] SLOTS_PER_SF = 9'h100;
  localparam logic [7:0] LAST_SLOT = 8'hFF;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SLOT_LEN = 8'h04;
  localparam logic [7:0] REG_BP_LEN = 8'h08;
  localparam logic [7:0] REG_HIB_CNT = 8'h0C;
  localparam logic [7:0] REG_ACK_CFG = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RESV_BASE = 8'h40;
  localparam logic [7:0] REG_PART_BASE = 8'h60;

  // Reset values and field positions
  localparam logic [15:0] RST_SLOT_LEN = 16'(SLOT_CYC);
  localparam logic [7:0] RST_BP_LEN = 8'h01;
  localparam logic [15:0] RST_ACK_TO = 16'(ACK_TO_CYC);
  localparam logic [3:0] RST_MAX_TRY = 4'h3;
  localparam logic [3:0] RST_MAX_AGE = 4'h2;
  localparam int CTRL_EN = 0;
  localparam int CTRL_HIB = 1;
  localparam int ACKF_TRY = 16;
  localparam int ACKF_AGE = 20;

  // Rate codes
  localparam logic [2:0] RATE_LOWEST = 3'h0;
  localparam logic [2:0] BEACON_PAYLOAD_RATE = 3'h0;

  typedef enum logic [1:0] {
    SFAT_ACK_NONE = 2'b00,
    SFAT_ACK_IMM = 2'b01,
    SFAT_ACK_BLK = 2'b10
  } sfat_ack_e;

  typedef enum logic [1:0] {
    SFAT_M_BEACON = 2'b00,
    SFAT_M_RESV = 2'b01,
    SFAT_M_CONT = 2'b10,
    SFAT_M_QUIET = 2'b11
  } sfat_mode_e;

  typedef enum logic {
    SFAT_A_IDLE = 1'b0,
    SFAT_A_WAIT = 1'b1
  } sfat_ast_e;

  typedef struct packed {
    logic is_bcn;
    logic use_resv;
    sfat_ack_e ack;
    logic blk_req;
    logic retx;
    logic retry_ok;
    logic [11:0] seq;
    logic [3:0] frag;
    logic [2:0] rate;
  } sfat_txreq_s;

  typedef struct packed {
    logic valid;
    logic is_bcn;
    logic [2:0] hdr_rate;
    logic [2:0] pay_rate;
    sfat_ack_e ack;
    logic [11:0] seq;
    logic [3:0] frag;
  } sfat_phytx_s;

  typedef struct packed {
    logic valid;
    logic [7:0] count;
  } sfat_hibie_s;
endpackage : sfat_pkg

// ---- sfat_top.sv ----
`timescale 1ns/1ps
module sfat_top import sfat_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Frame requests from the client
  input wire logic i_tx_valid,
  input wire sfat_txreq_s i_tx,
  output logic o_tx_ready,
  // Acknowledgement seen by the receiver path
  input wire logic i_ack_ok,
  // Towards the PHY and client
  output sfat_phytx_s o_phy_tx,
  output sfat_hibie_s o_hib_ie,
  output sfat_mode_e o_mode,
  output logic [7:0] o_slot,
  output logic o_beacon_period_start_time,
  output logic o_bcn_due,
  output logic o_rx_en,
  output logic o_tx_done,
  output logic o_retx,
  output logic o_discard
);

  // Configuration and reservation maps
  logic en_q, en_d;
  logic [15:0] slot_len_q, slot_len_d;
  logic [7:0] bp_len_q, bp_len_d;
  logic [7:0] hib_cnt_q, hib_cnt_d;
  logic [15:0] ack_to_q, ack_to_d;
  logic [3:0] max_try_q, max_try_d, max_age_q, max_age_d;
  logic [31:0] resv_q [8];
  logic [31:0] resv_d [8];
  logic [31:0] part_q [8];
  logic [31:0] part_d [8];
  logic [31:0] rdata_d;
  logic hib_cmd;

  // Slot timer state
  logic [15:0] cyc_q, cyc_d;
  logic [7:0] slot_q, slot_d;
  logic [7:0] sf_q, sf_d;
  logic beacon_period_start_time_q, beacon_period_start_time_d;
  logic slot_end;

  // Access and acknowledgement state
  sfat_mode_e mode;
  logic grant, allow;
  sfat_phytx_s ptx_d;
  sfat_ast_e ast_q, ast_d;
  logic [15:0] wait_q, wait_d;
  logic [3:0] try_q, try_d, age_q, age_d;
  logic rok_q, rok_d;
  logic done_d, retx_d, disc_d;

  // Power state
  logic pend_q, pend_d, ann_q, ann_d, hib_q, hib_d;
  logic [7:0] left_q, left_d;

  // Register writes; a zero slot length would make every slot 65536 cycles long, so it is forced to one
  always_comb begin
    en_d = en_q;
    slot_len_d = slot_len_q;
    bp_len_d = bp_len_q;
    hib_cnt_d = hib_cnt_q;
    ack_to_d = ack_to_q;
    max_try_d = max_try_q;
    max_age_d = max_age_q;
    resv_d = resv_q;
    part_d = part_q;
    hib_cmd = 1'b0;
    if (i_wr) begin
      unique case (i_addr)
        REG_CTRL: begin
          en_d = i_wdata[CTRL_EN];
          hib_cmd = i_wdata[CTRL_HIB];
        end
        REG_SLOT_LEN: slot_len_d = (i_wdata[15:0] == 16'h0000) ? 16'h0001 : i_wdata[15:0];
        REG_BP_LEN: bp_len_d = (i_wdata[7:0] == 8'h00) ? 8'h01 : i_wdata[7:0];
        REG_HIB_CNT: hib_cnt_d = i_wdata[7:0];
        REG_ACK_CFG: begin
          ack_to_d = i_wdata[15:0];
          max_try_d = i_wdata[ACKF_TRY +: 4];
          max_age_d = i_wdata[ACKF_AGE +: 4];
        end
        default: begin
          if (i_addr[7:5] == REG_RESV_BASE[7:5] && i_addr[1:0] == 2'b00) resv_d[i_addr[4:2]] = i_wdata;
          if (i_addr[7:5] == REG_PART_BASE[7:5] && i_addr[1:0] == 2'b00) part_d[i_addr[4:2]] = i_wdata;
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr)
        REG_CTRL: rdata_d = {31'h0, en_q};
        REG_SLOT_LEN: rdata_d = {16'h0, slot_len_q};
        REG_BP_LEN: rdata_d = {24'h0, bp_len_q};
        REG_HIB_CNT: rdata_d = {24'h0, hib_cnt_q};
        REG_ACK_CFG: rdata_d = {8'h0, max_age_q, max_try_q, ack_to_q};
        REG_STATUS: rdata_d = {sf_q, 1'b0, left_q, hib_q, ann_q, pend_q, ast_q, mode, 1'b0, slot_q};
        default: begin
          if (i_addr[7:5] == REG_RESV_BASE[7:5] && i_addr[1:0] == 2'b00) rdata_d = resv_q[i_addr[4:2]];
          if (i_addr[7:5] == REG_PART_BASE[7:5] && i_addr[1:0] == 2'b00) rdata_d = part_q[i_addr[4:2]];
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      en_q <= 1'b0;
      slot_len_q <= RST_SLOT_LEN;
      bp_len_q <= RST_BP_LEN;
      hib_cnt_q <= 8'h00;
      ack_to_q <= RST_ACK_TO;
      max_try_q <= RST_MAX_TRY;
      max_age_q <= RST_MAX_AGE;
      o_rdata <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
        resv_q[i] <= 32'h0000_0000;
        part_q[i] <= 32'h0000_0000;
      end
    end else begin
      en_q <= en_d;
      slot_len_q <= slot_len_d;
      bp_len_q <= bp_len_d;
      hib_cnt_q <= hib_cnt_d;
      ack_to_q <= ack_to_d;
      max_try_q <= max_try_d;
      max_age_q <= max_age_d;
      o_rdata <= rdata_d;
      resv_q <= resv_d;
      part_q <= part_d;
    end
  end

  // Slot timer: cycles within a slot, slot index, superframe count
  assign slot_end = (cyc_q == slot_len_q - 16'h0001);
  always_comb begin
    cyc_d = cyc_q;
    slot_d = slot_q;
    sf_d = sf_q;
    beacon_period_start_time_d = 1'b0;
    if (!en_q) begin
      cyc_d = 16'h0000;
      slot_d = 8'h00;
    end else if (slot_end) begin
      cyc_d = 16'h0000;
      slot_d = slot_q + 8'h01;
      if (slot_q == LAST_SLOT) begin
        sf_d = sf_q + 8'h01;
        beacon_period_start_time_d = 1'b1;
      end
    end else begin
      cyc_d = cyc_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cyc_q <= 16'h0000;
      slot_q <= 8'h00;
      sf_q <= 8'h00;
      beacon_period_start_time_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      slot_q <= slot_d;
      sf_q <= sf_d;
      beacon_period_start_time_q <= beacon_period_start_time_d;
    end
  end

  // Slot access mode; a slot reserved by others stays quiet for us
  always_comb begin
    if (!en_q || hib_q) mode = SFAT_M_QUIET;
    else if (slot_q < bp_len_q) mode = SFAT_M_BEACON;
    else if (resv_q[slot_q[7:5]][slot_q[4:0]]) begin
      mode = part_q[slot_q[7:5]][slot_q[4:0]] ? SFAT_M_RESV : SFAT_M_QUIET;
    end else mode = SFAT_M_CONT;
  end

  // Admission: frame kind must match the slot's access method
  always_comb begin
    unique case (mode)
      SFAT_M_BEACON: allow = i_tx.is_bcn;
      SFAT_M_RESV: allow = !i_tx.is_bcn && i_tx.use_resv && ast_q == SFAT_A_IDLE;
      SFAT_M_CONT: allow = !i_tx.is_bcn && !i_tx.use_resv && ast_q == SFAT_A_IDLE;
      SFAT_M_QUIET: allow = 1'b0;
    endcase
  end
  assign o_tx_ready = allow;
  assign grant = i_tx_valid && allow;

  // Descriptor to the PHY; header always at the lowest rate
  always_comb begin
    ptx_d = '0;
    if (grant) begin
      ptx_d.valid = 1'b1;
      ptx_d.is_bcn = i_tx.is_bcn;
      ptx_d.hdr_rate = RATE_LOWEST;
      ptx_d.pay_rate = i_tx.is_bcn ? BEACON_PAYLOAD_RATE : i_tx.rate;
      ptx_d.ack = i_tx.is_bcn ? SFAT_ACK_NONE : i_tx.ack;
      ptx_d.seq = i_tx.seq;
      ptx_d.frag = i_tx.frag;
    end
  end

  // Acknowledgement wait: retry while type, tries and age allow, else drop
  always_comb begin
    ast_d = ast_q;
    wait_d = wait_q;
    try_d = try_q;
    age_d = age_q;
    rok_d = rok_q;
    done_d = 1'b0;
    retx_d = 1'b0;
    disc_d = 1'b0;
    if (beacon_period_start_time_q && age_q != 4'hF) age_d = age_q + 4'h1;
    unique case (ast_q)
      SFAT_A_IDLE: begin
        if (grant && !i_tx.is_bcn) begin
          try_d = i_tx.retx ? try_q + 4'h1 : 4'h1;
          if (!i_tx.retx) age_d = 4'h0;
          rok_d = i_tx.retry_ok;
          wait_d = 16'h0000;
          if (i_tx.ack == SFAT_ACK_IMM || (i_tx.ack == SFAT_ACK_BLK && i_tx.blk_req)) ast_d = SFAT_A_WAIT;
          else done_d = 1'b1;
        end
      end
      SFAT_A_WAIT: begin
        wait_d = wait_q + 16'h0001;
        if (i_ack_ok) begin
          ast_d = SFAT_A_IDLE;
          done_d = 1'b1;
        end else if (wait_q >= ack_to_q) begin
          ast_d = SFAT_A_IDLE;
          if (rok_q && try_q < max_try_q && age_q < max_age_q) retx_d = 1'b1;
          else disc_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ast_q <= SFAT_A_IDLE;
      wait_q <= 16'h0000;
      try_q <= 4'h0;
      age_q <= 4'h0;
      rok_q <= 1'b0;
      o_phy_tx <= '0;
      o_tx_done <= 1'b0;
      o_retx <= 1'b0;
      o_discard <= 1'b0;
    end else begin
      ast_q <= ast_d;
      wait_q <= wait_d;
      try_q <= try_d;
      age_q <= age_d;
      rok_q <= rok_d;
      o_phy_tx <= ptx_d;
      o_tx_done <= done_d;
      o_retx <= retx_d;
      o_discard <= disc_d;
    end
  end

  // Hibernation: request, announce in our beacon, then sleep the count
  always_comb begin
    pend_d = pend_q;
    ann_d = ann_q;
    hib_d = hib_q;
    left_d = left_q;
    if (hib_cmd && hib_cnt_q != 8'h00 && !hib_q && !ann_q) pend_d = 1'b1;
    if (grant && i_tx.is_bcn && pend_q) begin
      pend_d = 1'b0;
      ann_d = 1'b1;
    end
    if (beacon_period_start_time_q) begin
      if (ann_q) begin
        ann_d = 1'b0;
        hib_d = 1'b1;
        left_d = hib_cnt_q;
      end else if (hib_q) begin
        left_d = left_q - 8'h01;
        if (left_q == 8'h01) hib_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_q <= 1'b0;
      ann_q <= 1'b0;
      hib_q <= 1'b0;
      left_q <= 8'h00;
    end else begin
      pend_q <= pend_d;
      ann_q <= ann_d;
      hib_q <= hib_d;
      left_q <= left_d;
    end
  end

  // Status outputs
  assign o_mode = mode;
  assign o_slot = slot_q;
  assign o_beacon_period_start_time = beacon_period_start_time_q;
  assign o_hib_ie = '{valid: pend_q, count: hib_cnt_q};
  assign o_bcn_due = beacon_period_start_time_q && en_q && !hib_q;
  assign o_rx_en = en_q && !hib_q;

  // Checks
  chk_slot_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    en_q && slot_end && slot_q == LAST_SLOT |=> slot_q == 8'h00 && beacon_period_start_time_q)
    else $error("slot index did not wrap at superframe end");
  chk_slot_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    en_q && slot_end && $stable(slot_len_q) |=> cyc_q == 16'h0000 && slot_q == $past(slot_q) + 8'h01)
    else $error("slot did not advance after its length");
  chk_beacon_period_start_time_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    beacon_period_start_time_q && en_q && !hib_q |-> slot_q == 8'h00 && mode == SFAT_M_BEACON)
    else $error("superframe start is not beacon slot zero");
  chk_bp_beacons: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    grant && slot_q < bp_len_q |-> i_tx.is_bcn)
    else $error("non-beacon granted in beacon period");
  chk_resv_part: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    grant && resv_q[slot_q[7:5]][slot_q[4:0]] && slot_q >= bp_len_q |-> part_q[slot_q[7:5]][slot_q[4:0]])
    else $error("transmit in reservation we do not join");
  chk_cont_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    grant && mode == SFAT_M_CONT |-> !i_tx.use_resv && !i_tx.is_bcn)
    else $error("contention slot used by other method");
  chk_frag_seq: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    grant |=> o_phy_tx.valid && o_phy_tx.seq == $past(i_tx.seq) && o_phy_tx.frag == $past(i_tx.frag))
    else $error("fragment numbering lost");
  chk_noack_done: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    grant && !i_tx.is_bcn && i_tx.ack == SFAT_ACK_NONE |=> o_tx_done && ast_q == SFAT_A_IDLE)
    else $error("no-ack frame waited for acknowledgement");
  chk_miss_ack: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ast_q == SFAT_A_WAIT && !i_ack_ok && wait_q >= ack_to_q |=> o_retx != o_discard)
    else $error("missing ack neither retried nor dropped");
  chk_bcn_rate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_phy_tx.valid && o_phy_tx.is_bcn |-> o_phy_tx.pay_rate == BEACON_PAYLOAD_RATE)
    else $error("beacon payload at wrong rate");
  chk_hdr_rate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_phy_tx.valid |-> o_phy_tx.hdr_rate == RATE_LOWEST)
    else $error("header not at lowest rate");
  chk_active_bcn: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    en_q && !hib_q && slot_end && slot_q == LAST_SLOT && !(i_wr && i_addr == REG_CTRL)
    |=> o_bcn_due && o_rx_en)
    else $error("active device skipped beacon");
  chk_hib_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    hib_q |-> !o_tx_ready && !o_rx_en ##1 !o_phy_tx.valid)
    else $error("traffic during hibernation");
  cov_superframe: cover property (@(posedge i_clk) disable iff (i_sys_rst) beacon_period_start_time_q && en_q);
  cov_retx: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_retx);
  cov_hibernate: cover property (@(posedge i_clk) disable iff (i_sys_rst) hib_q && beacon_period_start_time_q && left_q == 8'h01);
endmodule : sfat_top

// ---- sfat_peer_model.sv ----
`timescale 1ns/1ps
module sfat_peer_model import sfat_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Bench control
  input wire logic [7:0] i_ack_delay,
  input wire logic i_ack_mute,
  // Medium side
  input wire sfat_phytx_s i_phy_tx,
  output logic o_ack_ok
);
  logic [7:0] cnt_q;
  logic armed_q;

  // One answer per non-beacon frame whose ack policy is not none, block frames without request included; beacons and no-ack frames get none
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 8'h00;
      armed_q <= 1'b0;
      o_ack_ok <= 1'b0;
    end else begin
      o_ack_ok <= 1'b0;
      if (i_phy_tx.valid && !i_phy_tx.is_bcn && i_phy_tx.ack != SFAT_ACK_NONE && !i_ack_mute) begin
        armed_q <= 1'b1;
        cnt_q <= i_ack_delay;
      end else if (armed_q) begin
        // Delay lets the bench ask for prompt or slow answers
        if (cnt_q == 8'h00) begin
          armed_q <= 1'b0;
          o_ack_ok <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule : sfat_peer_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench import sfat_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic tx_valid = 1'b0;
  sfat_txreq_s tx = '0;
  logic tx_ready, ack_ok, beacon_period_start_time, bcn_due, rx_en, tx_done, retx, discard;
  sfat_phytx_s phy_tx;
  sfat_hibie_s hib_ie;
  sfat_mode_e mode;
  logic [7:0] slot;
  logic [7:0] ack_delay = 8'h08;
  logic ack_mute = 1'b0;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] d;
  longint t0;

  always #12.5 clk = ~clk;

  sfat_top i_sfat_top (.i_clk(clk), .i_sys_rst(sys_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_tx_valid(tx_valid), .i_tx(tx), .o_tx_ready(tx_ready), .i_ack_ok(ack_ok),
    .o_phy_tx(phy_tx), .o_hib_ie(hib_ie), .o_mode(mode), .o_slot(slot), .o_beacon_period_start_time(beacon_period_start_time), .o_bcn_due(bcn_due),
    .o_rx_en(rx_en), .o_tx_done(tx_done), .o_retx(retx), .o_discard(discard));

  sfat_peer_model i_sfat_peer_model (.i_clk(clk), .i_sys_rst(sys_rst), .i_ack_delay(ack_delay),
    .i_ack_mute(ack_mute), .i_phy_tx(phy_tx), .o_ack_ok(ack_ok));

  // Ends the run; also the exit of every exhausted wait
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic hang();
    num_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask : hang

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  function automatic bit hit(input int kind, input logic [7:0] s);
    case (kind)
      0: hit = (beacon_period_start_time === 1'b1);
      1: hit = (slot === s);
      default: hit = ((tx_done | retx | discard) === 1'b1);
    endcase
  endfunction : hit

  // Kind 0 superframe start, 1 slot s, 2 end of a frame
  task automatic wait_ev(input int kind, input logic [7:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!hit(kind, s) && n < 1200);
    if (n >= 1200) hang();
  endtask : wait_ev

  function automatic sfat_txreq_s mk(input logic bcn, input logic rsv, input sfat_ack_e ack, input logic blk,
    input logic rt, input logic [11:0] seq);
    mk = '{is_bcn: bcn, use_resv: rsv, ack: ack, blk_req: blk, retx: rt, retry_ok: 1'b1, seq: seq,
      frag: 4'h5, rate: 3'h5};
  endfunction : mk

  // Holds the offer until taken; returns just after the accepting edge
  task automatic offer(input sfat_txreq_s t);
    int n;
    n = 0;
    @(posedge clk);
    tx <= t;
    tx_valid <= 1'b1;
    #1;
    while (tx_ready !== 1'b1 && n < 1200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 1200) hang();
    @(posedge clk);
    tx_valid <= 1'b0;
    #1;
  endtask : offer

  task automatic refuse(input sfat_txreq_s t, input string what);
    @(posedge clk);
    tx <= t;
    tx_valid <= 1'b1;
    #1;
    check(32'(tx_ready), 32'h0, what);
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask : refuse

  task automatic t_reset();
    check(32'({slot, beacon_period_start_time, mode, rx_en}), 32'h6, "idle after reset");
    rd_reg(REG_SLOT_LEN, d);
    check(d, 32'(RST_SLOT_LEN), "slot length reset");
    rd_reg(REG_BP_LEN, d);
    check(d, 32'(RST_BP_LEN), "beacon period reset");
    rd_reg(REG_ACK_CFG, d);
    check(d, {8'h00, RST_MAX_AGE, RST_MAX_TRY, RST_ACK_TO}, "ack config reset");
    rd_reg(8'h30, d);
    check(d, 32'h0, "unmapped read");
  endtask : t_reset

  task automatic t_timing();
    wr_reg(REG_SLOT_LEN, 32'h4);
    wr_reg(REG_BP_LEN, 32'h2);
    wr_reg(REG_CTRL, 32'h1);
    check(32'(rx_en), 32'h1, "receiver on");
    wait_ev(0, 8'h00);
    check(32'(slot), 32'h0, "slot at start");
    check(32'(bcn_due), 32'h1, "beacon due");
    check(32'(mode), 32'(SFAT_M_BEACON), "first slot beacon");
    t0 = $time;
    wait_ev(0, 8'h00);
    check(32'(($time - t0) / CLK_PERIOD_NS), 32'(SLOTS_PER_SF) * 32'h4, "superframe length");
    wait_ev(1, 8'h01);
    check(32'(mode), 32'(SFAT_M_BEACON), "second slot beacon");
    wait_ev(1, 8'h02);
    check(32'(mode), 32'(SFAT_M_CONT), "free slot contention");
  endtask : t_timing

  task automatic t_frames();
    wait_ev(0, 8'h00);
    refuse(mk(1'b0, 1'b0, SFAT_ACK_NONE, 1'b0, 1'b0, 12'h001), "data in beacon period");
    offer(mk(1'b1, 1'b0, SFAT_ACK_IMM, 1'b0, 1'b0, 12'h002));
    check(32'({phy_tx.valid, phy_tx.is_bcn}), 32'h3, "beacon sent");
    check(32'(phy_tx.pay_rate), 32'(BEACON_PAYLOAD_RATE), "beacon payload rate");
    check(32'(phy_tx.hdr_rate), 32'(RATE_LOWEST), "beacon header rate");
    wait_ev(1, 8'h02);
    refuse(mk(1'b0, 1'b1, SFAT_ACK_NONE, 1'b0, 1'b0, 12'h003), "reservation frame in free slot");
    offer(mk(1'b0, 1'b0, SFAT_ACK_NONE, 1'b0, 1'b0, 12'hABC));
    check(32'({phy_tx.seq, phy_tx.frag}), 32'hABC5, "fragment numbering");
    check(32'({phy_tx.hdr_rate, phy_tx.pay_rate}), 32'h05, "header and payload rates");
    check(32'(tx_done), 32'h1, "no-ack completes");
    offer(mk(1'b0, 1'b0, SFAT_ACK_IMM, 1'b0, 1'b0, 12'h010));
    refuse(mk(1'b0, 1'b0, SFAT_ACK_NONE, 1'b0, 1'b0, 12'h011), "busy awaiting ack");
    wait_ev(2, 8'h00);
    check(32'({tx_done, retx, discard}), 32'h4, "immediate ack completes");
    ack_mute <= 1'b1;
    offer(mk(1'b0, 1'b0, SFAT_ACK_BLK, 1'b0, 1'b0, 12'h012));
    check(32'(tx_done), 32'h1, "block frame without request");
    // Peer samples the descriptor one edge later; keep it muted until then
    @(posedge clk);
    ack_mute <= 1'b0;
    offer(mk(1'b0, 1'b0, SFAT_ACK_BLK, 1'b1, 1'b0, 12'h013));
    wait_ev(2, 8'h00);
    check(32'({tx_done, retx, discard}), 32'h4, "block response completes");
  endtask : t_frames

  // Silent peer: two retries, then the try limit forces a drop
  task automatic t_retry();
    sfat_txreq_s t;
    ack_mute <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      offer(mk(1'b0, 1'b0, SFAT_ACK_IMM, 1'b0, i != 0, 12'h020));
      wait_ev(2, 8'h00);
      check(32'({retx, discard}), (i < 2) ? 32'h2 : 32'h1, "retry or drop");
    end
    t = mk(1'b0, 1'b0, SFAT_ACK_IMM, 1'b0, 1'b0, 12'h021);
    t.retry_ok = 1'b0;
    offer(t);
    wait_ev(2, 8'h00);
    check(32'({retx, discard}), 32'h1, "no-retry type dropped");
    // Age limit: two superframe starts pass before the resubmission
    offer(mk(1'b0, 1'b0, SFAT_ACK_IMM, 1'b0, 1'b0, 12'h022));
    wait_ev(2, 8'h00);
    check(32'({retx, discard}), 32'h2, "fresh frame retried");
    wait_ev(0, 8'h00);
    wait_ev(0, 8'h00);
    offer(mk(1'b0, 1'b0, SFAT_ACK_IMM, 1'b0, 1'b1, 12'h022));
    wait_ev(2, 8'h00);
    check(32'({retx, discard}), 32'h1, "aged frame dropped");
  endtask : t_retry

  task automatic t_resv();
    wr_reg(REG_RESV_BASE, 32'h60);
    wr_reg(REG_PART_BASE, 32'h20);
    wait_ev(1, 8'h05);
    check(32'(mode), 32'(SFAT_M_RESV), "own reservation");
    offer(mk(1'b0, 1'b1, SFAT_ACK_NONE, 1'b0, 1'b0, 12'h030));
    check(32'({phy_tx.valid, slot}), 32'h105, "sent in reserved slot");
    wait_ev(1, 8'h06);
    check(32'(mode), 32'(SFAT_M_QUIET), "foreign reservation");
    refuse(mk(1'b0, 1'b1, SFAT_ACK_NONE, 1'b0, 1'b0, 12'h031), "foreign reservation send");
  endtask : t_resv

  task automatic t_hib();
    wr_reg(REG_HIB_CNT, 32'h2);
    wr_reg(REG_CTRL, 32'h3);
    check(32'(hib_ie), 32'h102, "sleep announced");
    wait_ev(0, 8'h00);
    offer(mk(1'b1, 1'b0, SFAT_ACK_NONE, 1'b0, 1'b0, 12'h040));
    check(32'(hib_ie.valid), 32'h0, "announcement carried");
    wait_ev(0, 8'h00);
    wait_ev(1, 8'h01);
    check(32'({rx_en, mode}), 32'(SFAT_M_QUIET), "asleep");
    refuse(mk(1'b1, 1'b0, SFAT_ACK_NONE, 1'b0, 1'b0, 12'h041), "beacon while asleep");
    wait_ev(0, 8'h00);
    check(32'(bcn_due), 32'h0, "no beacon asleep");
    wait_ev(0, 8'h00);
    wait_ev(1, 8'h01);
    check(32'(rx_en), 32'h1, "awake again");
    wait_ev(0, 8'h00);
    check(32'(bcn_due), 32'h1, "beacon after wake");
  endtask : t_hib

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_timing();
    t_frames();
    t_retry();
    t_resv();
    t_hib();
    give_verdict();
  end
endmodule : testbench
